// ===== hw/ise_pkg.sv
// constants, types and command codes of the status and event reporting block
//
// Function
// - status byte ANDed with poll mask, bit 6 included
// - individual flag is OR of masked bits
// - flag reported on poll and flag query
// - poll mask written and read back unchanged
// - event enable mask written and read back
// - event status latched, returned on its query
// - operation complete sets bit 0 when idle
// - query errors set event bit 2
// - device errors set bit 3, queue code
// - execution errors set bit 4, queue code
// - command errors set bit 5, queue code
// - local key sets event bit 6
// - power on sets event bit 7
// - operation condition and event parts, separate queries
// - condition bit 0 follows calibration
// - condition bit 8 follows hardcopy printing
// - bit 9 on scan block, feed always only
// - bit 10 on sweep end, continue proceeds
// - operation bit 15 always zero
// - unused positions carry no function
// - status bit 5 summarises enabled events
// - status bit 7 summarises enabled operations
package ise_pkg;

   // event status bit positions
   localparam int EV_OPC_BIT = 0;
   localparam int EV_QUERY_BIT = 2;
   localparam int EV_DEVICE_BIT = 3;
   localparam int EV_EXEC_BIT = 4;
   localparam int EV_CMD_BIT = 5;
   localparam int EV_USER_BIT = 6;
   localparam int EV_POWER_BIT = 7;
   localparam logic [7:0] EV_USED_MASK = 8'hFD;
   localparam logic [7:0] EV_RESET = 8'h80;

   // operation bit positions
   localparam int OP_CAL_BIT = 0;
   localparam int OP_MEAS_BIT = 4;
   localparam int OP_HCOPY_BIT = 8;
   localparam int OP_SCAN_BIT = 9;
   localparam int OP_SWEEP_BIT = 10;
   localparam int OP_THRESH_BIT = 13;
   localparam logic [15:0] OP_USED_MASK = 16'h2711;

   // status byte bit positions
   localparam int SB_ERRQ_BIT = 2;
   localparam int SB_QUES_BIT = 3;
   localparam int SB_MAV_BIT = 4;
   localparam int SB_EVSUM_BIT = 5;
   localparam int SB_MSS_BIT = 6;
   localparam int SB_OPER_BIT = 7;

   // reset values of the masks and registers
   localparam logic [7:0] PPOLL_MASK_RESET = 8'h00;
   localparam logic [7:0] EV_MASK_RESET = 8'h00;
   localparam logic [15:0] OP_ENABLE_RESET = 16'h0000;
   localparam logic [15:0] OP_COND_RESET = 16'h0000;
   localparam logic [15:0] OP_EVENT_RESET = 16'h0000;
   localparam logic [7:0] STATUS_BYTE_RESET = 8'h00;

   // error code ranges, inclusive bounds
   localparam logic signed [15:0] ERR_CMD_HI = -16'sd100;
   localparam logic signed [15:0] ERR_CMD_LO = -16'sd199;
   localparam logic signed [15:0] ERR_EXEC_HI = -16'sd200;
   localparam logic signed [15:0] ERR_EXEC_LO = -16'sd299;
   localparam logic signed [15:0] ERR_DEV_HI = -16'sd300;
   localparam logic signed [15:0] ERR_DEV_LO = -16'sd399;

   typedef enum logic [3:0] {
      CMD_NONE,
      CMD_PPOLL_WR,
      CMD_PPOLL_RD,
      CMD_EVMASK_WR,
      CMD_EVMASK_RD,
      CMD_EVSTAT_RD,
      CMD_FLAG_RD,
      CMD_OPC,
      CMD_OPCOND_RD,
      CMD_OPEVT_RD,
      CMD_OPENA_WR,
      CMD_OPENA_RD,
      CMD_CONTINUE
   } ise_cmd_op_t;

   typedef struct packed {
      logic valid;
      ise_cmd_op_t op;
      logic [15:0] data;
   } ise_cmd_t;

   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } ise_rsp_t;

   typedef struct packed {
      logic push;
      logic signed [15:0] code;
   } ise_err_t;

endpackage

// ===== hw/ise_status_event_logic.sv
// status byte summary, event status, poll flag and operation registers
module ise_status_event_logic
   import ise_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire ise_cmd_t cmdIn,
   output ise_rsp_t rspOut,
   input wire logic allCmdsDone,
   input wire logic readWithoutQuery,
   input wire logic newCmdBeforeFetch,
   input wire ise_err_t errIn,
   output ise_err_t errQueueOut,
   input wire logic localKey,
   input wire logic calibrating,
   input wire logic measuring,
   input wire logic hardcopyBusy,
   input wire logic scanBlockReady,
   input wire logic continuousResultFeedAlways,
   input wire logic sweepRangeEnd,
   input wire logic thresholdActive,
   input wire logic errQueueNotEmpty,
   input wire logic questionableSum,
   input wire logic messageAvailable,
   input wire logic masterSummary,
   output logic [7:0] statusByte,
   output logic istFlag
);

   ////////////////////////////////////////////////////////////////////////////
   // error code classification

   function automatic logic [7:0] classify_error(input logic signed [15:0] code);
      logic [7:0] bits;
      bits = 8'h00;
      if (code <= ERR_CMD_HI && code >= ERR_CMD_LO) begin
         bits[EV_CMD_BIT] = 1'b1;
      end else if (code <= ERR_EXEC_HI && code >= ERR_EXEC_LO) begin
         bits[EV_EXEC_BIT] = 1'b1;
      end else if ((code <= ERR_DEV_HI && code >= ERR_DEV_LO) || code > 16'sd0) begin
         bits[EV_DEVICE_BIT] = 1'b1;
      end
      return bits;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // command decoding

   // one place decides whether a strobe carries a given command, except the query answers, which decode cmdIn.op under cmdHit
   function automatic logic cmd_is(input ise_cmd_t c, input ise_cmd_op_t op);
      return c.valid && (c.op == op);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   logic [7:0] ppollMask_q;
   logic [7:0] ppollMask_d;
   logic [7:0] evMask_q;
   logic [7:0] evMask_d;
   logic [7:0] evStatus_q;
   logic [7:0] evStatus_d;
   logic [15:0] opEnable_q;
   logic [15:0] opEnable_d;
   logic [15:0] opCond_q;
   logic [15:0] opCond_d;
   logic [15:0] opEvent_q;
   logic [15:0] opEvent_d;
   logic opcPending_q;
   logic opcPending_d;
   logic sweepHeld_q;
   logic sweepHeld_d;
   ise_rsp_t rsp_q;
   ise_rsp_t rsp_d;
   ise_err_t errQ_q;
   logic [7:0] statusByte_q;
   logic [7:0] statusByte_d;
   logic istFlag_q;
   logic istFlag_d;

   logic [7:0] evSet;
   logic [7:0] evClr;
   logic [15:0] opSet;
   logic [15:0] opClr;
   logic cmdHit;

   assign cmdHit = cmdIn.valid;

   ////////////////////////////////////////////////////////////////////////////
   // masks written by the controller

   always_comb begin
      ppollMask_d = ppollMask_q;
      evMask_d = evMask_q;
      opEnable_d = opEnable_q;
      if (cmd_is(cmdIn, CMD_PPOLL_WR)) begin
         ppollMask_d = cmdIn.data[7:0];
      end
      if (cmd_is(cmdIn, CMD_EVMASK_WR)) begin
         evMask_d = cmdIn.data[7:0];
      end
      if (cmd_is(cmdIn, CMD_OPENA_WR)) begin
         opEnable_d = cmdIn.data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ppollMask_q <= PPOLL_MASK_RESET;
      end else begin
         ppollMask_q <= ppollMask_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         evMask_q <= EV_MASK_RESET;
      end else begin
         evMask_q <= evMask_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         opEnable_q <= OP_ENABLE_RESET;
      end else begin
         opEnable_q <= opEnable_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operation complete tracking

   // pending flag survives until the execution side reports idle
   always_comb begin
      opcPending_d = opcPending_q;
      if (cmd_is(cmdIn, CMD_OPC)) begin
         opcPending_d = 1'b1;
      end else if (opcPending_q && allCmdsDone) begin
         opcPending_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         opcPending_q <= 1'b0;
      end else begin
         opcPending_q <= opcPending_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // event status register

   always_comb begin
      evSet = 8'h00;
      evSet[EV_OPC_BIT] = opcPending_q && allCmdsDone;
      evSet[EV_QUERY_BIT] = readWithoutQuery || newCmdBeforeFetch;
      if (errIn.push) begin
         evSet = evSet | classify_error(errIn.code);
      end
      evSet[EV_USER_BIT] = localKey;
      evSet = evSet & EV_USED_MASK;
   end

   // read returns the latched value, clears, and a new event in the
   // same cycle still survives
   always_comb begin
      evClr = 8'h00;
      if (cmd_is(cmdIn, CMD_EVSTAT_RD)) begin
         evClr = 8'hFF;
      end
      evStatus_d = ((evStatus_q & ~evClr) | evSet) & EV_USED_MASK;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         evStatus_q <= EV_RESET;
      end else begin
         evStatus_q <= evStatus_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // error queue forwarding

   // the queue itself lives elsewhere; codes pass through one flop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         errQ_q <= '0;
      end else begin
         errQ_q.push <= errIn.push;
         errQ_q.code <= errIn.code;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operation condition part

   // sweep end holds until the controller sends the continue command
   always_comb begin
      sweepHeld_d = sweepHeld_q;
      if (sweepRangeEnd) begin
         sweepHeld_d = 1'b1;
      end else if (cmd_is(cmdIn, CMD_CONTINUE)) begin
         sweepHeld_d = 1'b0;
      end
   end

   always_comb begin
      opCond_d = 16'h0000;
      opCond_d[OP_CAL_BIT] = calibrating;
      opCond_d[OP_MEAS_BIT] = measuring;
      opCond_d[OP_HCOPY_BIT] = hardcopyBusy;
      // a scan block is a momentary condition; feed off means no report
      opCond_d[OP_SCAN_BIT] = scanBlockReady && continuousResultFeedAlways;
      opCond_d[OP_SWEEP_BIT] = sweepHeld_d;
      opCond_d[OP_THRESH_BIT] = thresholdActive;
      opCond_d = opCond_d & OP_USED_MASK;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sweepHeld_q <= 1'b0;
      end else begin
         sweepHeld_q <= sweepHeld_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         opCond_q <= OP_COND_RESET;
      end else begin
         opCond_q <= opCond_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operation event part

   always_comb begin
      opSet = opCond_d & ~opCond_q;
      opClr = 16'h0000;
      if (cmd_is(cmdIn, CMD_OPEVT_RD)) begin
         opClr = 16'hFFFF;
      end
      opEvent_d = ((opEvent_q & ~opClr) | opSet) & OP_USED_MASK;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         opEvent_q <= OP_EVENT_RESET;
      end else begin
         opEvent_q <= opEvent_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status byte and individual status flag

   always_comb begin
      statusByte_d = 8'h00;
      statusByte_d[SB_ERRQ_BIT] = errQueueNotEmpty;
      statusByte_d[SB_QUES_BIT] = questionableSum;
      statusByte_d[SB_MAV_BIT] = messageAvailable;
      statusByte_d[SB_EVSUM_BIT] = |(evStatus_d & evMask_d);
      statusByte_d[SB_MSS_BIT] = masterSummary;
      statusByte_d[SB_OPER_BIT] = |(opEvent_d & opEnable_d);
   end

   // unlike service request masking, bit 6 counts here too
   always_comb begin
      istFlag_d = |(statusByte_d & ppollMask_d);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         statusByte_q <= STATUS_BYTE_RESET;
      end else begin
         statusByte_q <= statusByte_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         istFlag_q <= 1'b0;
      end else begin
         istFlag_q <= istFlag_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // query answers

   // answers show values before this cycle's clear or write
   always_comb begin
      rsp_d.valid = 1'b0;
      rsp_d.data = 16'h0000;
      if (cmdHit) begin
         case (cmdIn.op)
            CMD_PPOLL_RD: begin
               rsp_d.valid = 1'b1;
               rsp_d.data = {8'h00, ppollMask_q};
            end
            CMD_EVMASK_RD: begin
               rsp_d.valid = 1'b1;
               rsp_d.data = {8'h00, evMask_q};
            end
            CMD_EVSTAT_RD: begin
               rsp_d.valid = 1'b1;
               rsp_d.data = {8'h00, evStatus_q};
            end
            CMD_FLAG_RD: begin
               rsp_d.valid = 1'b1;
               rsp_d.data = {15'h0000, istFlag_q};
            end
            CMD_OPCOND_RD: begin
               rsp_d.valid = 1'b1;
               rsp_d.data = opCond_q;
            end
            CMD_OPEVT_RD: begin
               rsp_d.valid = 1'b1;
               rsp_d.data = opEvent_q;
            end
            CMD_OPENA_RD: begin
               rsp_d.valid = 1'b1;
               rsp_d.data = opEnable_q;
            end
            default: begin
               rsp_d.valid = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_q <= '0;
      end else begin
         rsp_q <= rsp_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign rspOut = rsp_q;
   assign errQueueOut = errQ_q;
   assign statusByte = statusByte_q;
   assign istFlag = istFlag_q;

endmodule // ise_status_event_logic

// ===== tb/ise_status_event_logic_checker.sv
// concurrent checks on the status and event block ports
module ise_status_event_logic_checker
   import ise_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire ise_cmd_t cmdIn,
   input wire ise_rsp_t rspOut,
   input wire ise_err_t errIn,
   input wire ise_err_t errQueueOut,
   input wire logic calibrating,
   input wire logic hardcopyBusy,
   input wire logic [7:0] statusByte,
   input wire logic istFlag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   a_read_gets_answer: assert property (cmdIn.valid && cmdIn.op inside {CMD_PPOLL_RD, CMD_EVMASK_RD,
      CMD_EVSTAT_RD, CMD_FLAG_RD, CMD_OPCOND_RD, CMD_OPEVT_RD, CMD_OPENA_RD} |=> rspOut.valid)
      else $error("read command got no answer");
   a_write_silent: assert property (cmdIn.valid && cmdIn.op inside {CMD_PPOLL_WR, CMD_EVMASK_WR,
      CMD_OPC, CMD_OPENA_WR, CMD_CONTINUE} |=> !rspOut.valid)
      else $error("write command answered");
   a_op_unused_zero: assert property (cmdIn.valid && cmdIn.op inside {CMD_OPCOND_RD, CMD_OPEVT_RD}
      |=> (rspOut.data & ~OP_USED_MASK) == 16'h0000)
      else $error("unused operation bit read as one");
   a_ev_unused_zero: assert property (cmdIn.valid && cmdIn.op == CMD_EVSTAT_RD
      |=> (rspOut.data & ~{8'h00, EV_USED_MASK}) == 16'h0000)
      else $error("unused event bit read as one");
   a_flag_answer: assert property (cmdIn.valid && cmdIn.op == CMD_FLAG_RD
      |=> rspOut.data == {15'h0000, $past(istFlag)})
      else $error("flag query disagrees with flag");
   a_err_forward: assert property (errIn.push |=> errQueueOut.push && errQueueOut.code == $past(errIn.code))
      else $error("error report not forwarded");
   a_cal_cond: assert property (cmdIn.valid && cmdIn.op == CMD_OPCOND_RD
      |=> rspOut.data[OP_CAL_BIT] == $past(calibrating, 2))
      else $error("calibration condition wrong");
   a_hcopy_cond: assert property (cmdIn.valid && cmdIn.op == CMD_OPCOND_RD
      |=> rspOut.data[OP_HCOPY_BIT] == $past(hardcopyBusy, 2))
      else $error("hardcopy condition wrong");
   a_flag_needs_bits: assert property (statusByte == 8'h00 |-> !istFlag)
      else $error("flag set with empty status byte");
endmodule // ise_status_event_logic_checker

bind ise_status_event_logic ise_status_event_logic_checker u_chk (
   .clk(clk),
   .rst_n(rst_n),
   .cmdIn(cmdIn),
   .rspOut(rspOut),
   .errIn(errIn),
   .errQueueOut(errQueueOut),
   .calibrating(calibrating),
   .hardcopyBusy(hardcopyBusy),
   .statusByte(statusByte),
   .istFlag(istFlag)
);

// ===== tb/ise_host_model.sv
// remote controller model issuing one command at a time
module ise_host_model
   import ise_pkg::*;
(
   input wire logic clk,
   input wire ise_rsp_t rspIn,
   output ise_cmd_t cmdOut
);
   timeunit 1ns;
   timeprecision 1ps;
   initial cmdOut = '0;
   // strobe stands for one edge; answer taken at the next edge, so callers resume on an edge
   task automatic xfer(input ise_cmd_op_t op, input logic [15:0] wd, output logic [15:0] d, output logic v);
      @(posedge clk);
      cmdOut <= '{valid: 1'b1, op: op, data: wd};
      @(posedge clk);
      cmdOut <= '0;
      @(posedge clk);
      d = rspIn.data;
      v = rspIn.valid;
   endtask
endmodule // ise_host_model

// ===== tb/ise_status_event_logic_tb.sv
// self-checking bench for the status and event block
module ise_status_event_logic_tb
   import ise_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0;
   logic allCmdsDone = 1'b0, readWithoutQuery = 1'b0, newCmdBeforeFetch = 1'b0, localKey = 1'b0;
   logic calibrating = 1'b0, hardcopyBusy = 1'b0, scanBlockReady = 1'b0, feedAlways = 1'b0;
   logic sweepRangeEnd = 1'b0, masterSummary = 1'b0, msgAvail = 1'b0;
   ise_err_t errIn = '0;
   ise_cmd_t cmd;
   ise_rsp_t rsp;
   logic [7:0] statusByte;
   int mismatches = 0, n_checks = 0, cyc = 0;
   logic signed [15:0] codes [7] = '{-16'sh0064, -16'sh00C7, -16'sh00C8, -16'sh012B, -16'sh012C, -16'sh018F, 16'sh0005};
   logic [15:0] evExp [10] = '{16'h0020, 16'h0020, 16'h0010, 16'h0010, 16'h0008, 16'h0008, 16'h0008,
      16'h0004, 16'h0004, 16'h0040};
   always #5 clk = ~clk;
   ise_host_model host (.clk(clk), .rspIn(rsp), .cmdOut(cmd));
   ise_status_event_logic dut (.clk(clk), .rst_n(rst_n), .cmdIn(cmd), .rspOut(rsp), .allCmdsDone(allCmdsDone),
      .readWithoutQuery(readWithoutQuery), .newCmdBeforeFetch(newCmdBeforeFetch), .errIn(errIn),
      .errQueueOut(), .localKey(localKey), .calibrating(calibrating), .measuring(1'b0),
      .hardcopyBusy(hardcopyBusy), .scanBlockReady(scanBlockReady), .continuousResultFeedAlways(feedAlways),
      .sweepRangeEnd(sweepRangeEnd), .thresholdActive(1'b0), .errQueueNotEmpty(1'b0), .questionableSum(1'b0),
      .messageAvailable(msgAvail), .masterSummary(masterSummary), .statusByte(statusByte), .istFlag());
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic rd(input ise_cmd_op_t op, input logic [15:0] exp);
      logic [15:0] d;
      logic v;
      host.xfer(op, 16'h0000, d, v);
      check("answer valid", {15'h0000, v}, 16'h0001);
      check(op.name(), d, exp);
   endtask
   task automatic wr(input ise_cmd_op_t op, input logic [15:0] wd);
      logic [15:0] d;
      logic v;
      host.xfer(op, wd, d, v);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one event source per index, all pulses one cycle wide
   task automatic kick(input int i);
      @(posedge clk);
      if (i < 7) errIn <= '{push: 1'b1, code: codes[i]};
      else if (i == 7) readWithoutQuery <= 1'b1;
      else if (i == 8) newCmdBeforeFetch <= 1'b1;
      else localKey <= 1'b1;
      @(posedge clk);
      errIn <= '0;
      readWithoutQuery <= 1'b0;
      newCmdBeforeFetch <= 1'b0;
      localKey <= 1'b0;
      idle(2);
   endtask
   task automatic tally_and_finish();
      if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      idle(20);
      rst_n <= 1'b1;
      rd(CMD_EVSTAT_RD, 16'h0080);
      rd(CMD_EVSTAT_RD, 16'h0000);
      wr(CMD_PPOLL_WR, 16'h00A5);
      rd(CMD_PPOLL_RD, 16'h00A5);
      wr(CMD_EVMASK_WR, 16'h003C);
      rd(CMD_EVMASK_RD, 16'h003C);
      for (int i = 0; i < 10; i++) begin
         kick(i);
         rd(CMD_EVSTAT_RD, evExp[i]);
      end
      wr(CMD_OPC, 16'h0000);
      idle(3);
      rd(CMD_EVSTAT_RD, 16'h0000);
      allCmdsDone <= 1'b1;
      idle(3);
      rd(CMD_EVSTAT_RD, 16'h0001);
      // poll mask bit 6 must count, unlike the service mask
      masterSummary <= 1'b1;
      wr(CMD_PPOLL_WR, 16'h0040);
      idle(2);
      rd(CMD_FLAG_RD, 16'h0001);
      wr(CMD_PPOLL_WR, 16'h00BF);
      idle(2);
      rd(CMD_FLAG_RD, 16'h0000);
      masterSummary <= 1'b0;
      msgAvail <= 1'b1;
      wr(CMD_PPOLL_WR, 16'h0010);
      idle(2);
      rd(CMD_FLAG_RD, 16'h0001);
      msgAvail <= 1'b0;
      wr(CMD_EVMASK_WR, 16'h0040);
      wr(CMD_PPOLL_WR, 16'h0020);
      kick(9);
      check("summary bit", {15'h0000, statusByte[SB_EVSUM_BIT]}, 16'h0001);
      rd(CMD_FLAG_RD, 16'h0001);
      rd(CMD_EVSTAT_RD, 16'h0040);
      idle(2);
      rd(CMD_FLAG_RD, 16'h0000);
      wr(CMD_OPENA_WR, 16'h0001);
      calibrating <= 1'b1;
      idle(3);
      check("oper summary", {15'h0000, statusByte[SB_OPER_BIT]}, 16'h0001);
      rd(CMD_OPCOND_RD, 16'h0001);
      rd(CMD_OPEVT_RD, 16'h0001);
      rd(CMD_OPEVT_RD, 16'h0000);
      calibrating <= 1'b0;
      hardcopyBusy <= 1'b1;
      idle(3);
      rd(CMD_OPCOND_RD, 16'h0100);
      hardcopyBusy <= 1'b0;
      rd(CMD_OPEVT_RD, 16'h0100);
      for (int f = 0; f < 2; f++) begin
         feedAlways <= f[0];
         @(posedge clk) scanBlockReady <= 1'b1;
         @(posedge clk) scanBlockReady <= 1'b0;
         idle(2);
         rd(CMD_OPEVT_RD, f ? 16'h0200 : 16'h0000);
      end
      @(posedge clk) sweepRangeEnd <= 1'b1;
      @(posedge clk) sweepRangeEnd <= 1'b0;
      idle(5);
      rd(CMD_OPCOND_RD, 16'h0400);
      wr(CMD_CONTINUE, 16'h0000);
      idle(2);
      rd(CMD_OPCOND_RD, 16'h0000);
      rd(CMD_OPEVT_RD, 16'h0400);
      rd(CMD_OPENA_RD, 16'h0001);
      // power cycle in mid-run must raise the power-on event again
      rst_n <= 1'b0;
      idle(2);
      rst_n <= 1'b1;
      rd(CMD_EVSTAT_RD, 16'h0080);
      tally_and_finish();
   end
endmodule // ise_status_event_logic_tb
